// [flowthrough_sram_cycle_decode_bench.sv]
// Self-checking bench of the flow-through SRAM cycle decoder.
`timescale 1ns/1ns
module flowthrough_sram_cycle_decode_bench;
	localparam logic [2:0] ON = 3'b010;
	logic clk_sys, srst;
	logic chip_sel_first_n, chip_sel_second_hi, chip_sel_third_n;
	logic sleep_request, advance_or_load, write_en_n, clock_enable_n;
	logic out_en_n, burst_order, data_oe_n, parity_oe_n;
	logic [3:0] byte_write_sel_n, parity_in, parity_pins_out;
	logic [19:0] addr;
	logic [31:0] data_in, data_out;
	logic [35:0] em [64];
	int miscompares = 0;
	int n_checks = 0;

	host_bus_model i_host_bus_model (.clk_sys, .addr, .chip_sel_first_n,
		.chip_sel_second_hi, .chip_sel_third_n, .sleep_request,
		.advance_or_load, .write_en_n, .byte_write_sel_n, .clock_enable_n,
		.out_en_n, .burst_order, .data_in, .parity_in);
	sram_cycle_decode i_sram_cycle_decode (.clk_sys, .srst, .addr,
		.chip_sel_first_n, .chip_sel_second_hi, .chip_sel_third_n,
		.sleep_request, .advance_or_load, .write_en_n, .byte_write_sel_n,
		.clock_enable_n, .out_en_n, .burst_order, .data_in, .parity_in,
		.data_out, .data_oe_n, .parity_pins_out, .parity_oe_n);

	task chk(input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task c(input logic [2:0] s, input logic l, input logic w,
		input logic [3:0] b, input logic [19:0] a, input logic [31:0] d,
		input logic h = 1'b0);
		i_host_bus_model.cyc(s, l, w, b, a, d, h);
	endtask : c

	task wm(input logic [5:0] a, input logic [3:0] bw, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			if (!bw[i])
				{em[a][32+i], em[a][8*i +: 8]} = {~d[i], d[8*i +: 8]};
	endtask : wm

	task t_lanes;
		logic [3:0] bws [6];
		logic [3:0] pb;
		logic [31:0] d;
		bws = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h0};
		pb = 4'h0;
		c(ON, 0, 0, pb, 20'h0_0023, 0);
		for (int k = 0; k < 6; k++) begin
			d = 32'h0101_0101 * (k + 1);
			c(ON, 0, k == 5, bws[k], 20'h0_0023, d);
			wm(6'h23, pb, d);
			pb = bws[k];
			chk(data_oe_n, 1'b1);
		end
		c(3'b101, 0, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h23]);
		chk(data_oe_n, 1'b0);
		$display("lanes test done");
	endtask : t_lanes

	task t_burst;
		logic [2:0] off [3];
		off = '{3'b110, 3'b000, 3'b011};
		c(ON, 0, 0, 4'h0, 20'h0_0021, 0);
		c(0, 1, 1, 4'h0, 0, 32'h1212_3434);
		wm(6'h21, 4'h0, 32'h1212_3434);
		c(0, 1, 0, 4'hf, 0, 32'h5656_7878);
		wm(6'h22, 4'h0, 32'h5656_7878);
		c(0, 1, 1, 4'h0, 0, 32'h9a9a_bcbc);
		c(ON, 0, 0, 4'hf, 20'h0_0020, 32'hdede_f0f0);
		wm(6'h20, 4'h0, 32'hdede_f0f0);
		i_host_bus_model.order_v = 1'b1;
		i_host_bus_model.oe_n_v = 1'b1;
		c(ON, 0, 1, 4'hf, 20'h0_0021, 32'h1357_9bdf);
		c(0, 1, 1, 4'hf, 0, 0);
		chk(data_oe_n, 1'b1);
		i_host_bus_model.oe_n_v = 1'b0;
		c(ON, 0, 0, 4'h0, 20'h0_0002, 0, 1'b1);
		chk(data_oe_n, 1'b0);
		chk({parity_pins_out, data_out}, em[6'h20]);
		c(0, 1, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h20]);
		c(0, 1, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h23]);
		c(off[0], 0, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h22]);
		for (int k = 0; k < 5; k++) begin
			c(k < 3 ? off[k] : 3'b000, k > 2, 1, 4'hf, 0, 0);
			chk(data_oe_n, 1'b1);
		end
		$display("burst test done");
	endtask : t_burst

	task t_sleep;
		i_host_bus_model.sleep_v = 1'b1;
		for (int k = 0; k < 4; k++) begin
			c(k == 0 ? 3'b101 : ON, 0, 1, 4'hf, 20'h0_0023, 0);
			chk(data_oe_n, 1'b1);
		end
		i_host_bus_model.sleep_v = 1'b0;
		for (int k = 0; k < 4; k++) begin
			c(k < 3 ? 3'b101 : ON, 0, 1, 4'hf, 20'h0_0021, 0);
			chk(data_oe_n, 1'b1);
		end
		c(3'b101, 0, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h21]);
		$display("sleep test done");
	endtask : t_sleep

	// A stall between address and data must not take the data early.
	task t_stall;
		c(ON, 0, 0, 4'h0, 20'h0_0024, 0);
		c(0, 1, 1, 4'hf, 0, 32'h2468_ace0, 1'b1);
		c(3'b101, 0, 1, 4'hf, 0, 32'h1122_3344);
		wm(6'h24, 4'h0, 32'h1122_3344);
		c(ON, 0, 1, 4'hf, 20'h0_0024, 0);
		c(3'b101, 0, 1, 4'hf, 0, 0);
		chk({parity_pins_out, data_out}, em[6'h24]);
		chk(data_oe_n, 1'b0);
		$display("stall test done");
	endtask : t_stall

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		test_done();
	end

	initial begin
		srst = 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		chk({parity_oe_n, data_oe_n}, 2'b11);
		t_lanes();
		t_burst();
		t_sleep();
		t_stall();
		test_done();
	end
endmodule : flowthrough_sram_cycle_decode_bench

// [host_bus_model.sv]
// Host memory controller model that drives one SRAM bus cycle per call.
`timescale 1ns/1ns
module host_bus_model (
	input wire logic clk_sys,
	output logic [19:0] addr,
	output logic chip_sel_first_n,
	output logic chip_sel_second_hi,
	output logic chip_sel_third_n,
	output logic sleep_request,
	output logic advance_or_load,
	output logic write_en_n,
	output logic [3:0] byte_write_sel_n,
	output logic clock_enable_n,
	output logic out_en_n,
	output logic burst_order,
	output logic [31:0] data_in,
	output logic [3:0] parity_in
);
	logic oe_n_v = 1'b0;
	logic order_v = 1'b0;
	logic sleep_v = 1'b0;

	initial begin
		{chip_sel_first_n, chip_sel_second_hi, chip_sel_third_n} = 3'b101;
		{sleep_request, advance_or_load, write_en_n} = 3'b001;
		{byte_write_sel_n, clock_enable_n, out_en_n, burst_order} = 7'h78;
		addr = 20'h0_0000;
		data_in = 32'h0000_0000;
		parity_in = 4'h0;
	end

	// Zero data means a released bus: the lines toggle so stale data
	// can never pass for a fresh write beat.
	task cyc(input logic [2:0] sel, input logic aol, input logic we_n,
		input logic [3:0] bw, input logic [19:0] a, input logic [31:0] d,
		input logic hold);
		@(posedge clk_sys);
		{chip_sel_first_n, chip_sel_second_hi, chip_sel_third_n} <= sel;
		advance_or_load <= aol;
		write_en_n <= we_n;
		byte_write_sel_n <= bw;
		addr <= a;
		data_in <= d == 32'h0 ? ~data_in : d;
		parity_in <= d == 32'h0 ? ~parity_in : ~d[3:0];
		clock_enable_n <= hold;
		out_en_n <= oe_n_v;
		burst_order <= order_v;
		sleep_request <= sleep_v;
		#1;
	endtask : cyc
endmodule : host_bus_model

// [sram_array.sv]
// Storage array with per-lane write enables and an asynchronous read port.
`timescale 1ns/1ns
module sram_array #(
	parameter int ADDR_W = 20,
	parameter int LANES = 4,
	parameter int BYTE_W = 8
) (
	input wire logic clk_sys,
	sram_core_if.array link
);
	localparam int WORDS = 1 << ADDR_W;

	logic [LANES*BYTE_W-1:0] data_mem [WORDS];
	logic [LANES-1:0] par_mem [WORDS];

	// Unselected lanes keep their old contents.
	always_ff @(posedge clk_sys) begin
		if (link.wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (link.wr_lane[i]) begin
					data_mem[link.wr_addr][i*BYTE_W +: BYTE_W] <=
						link.wr_data[i*BYTE_W +: BYTE_W]; // R15
					par_mem[link.wr_addr][i] <= link.wr_par[i]; // R15
				end
			end
		end
	end

	assign link.rd_data = data_mem[link.rd_addr];
	assign link.rd_par = par_mem[link.rd_addr];
endmodule : sram_array

// [sram_burst_counter.sv]
// Two-bit burst counter with linear or interleaved order.
`timescale 1ns/1ns
module sram_burst_counter
	import sram_cycle_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	sram_core_if.burst link
);
	logic [1:0] first_lo;
	logic [1:0] beat;

	// Count wraps after four beats; a held counter is how stalls resume.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			first_lo <= BURST_CNT_RST;
			beat <= BURST_CNT_RST;
		end else if (link.load) begin
			first_lo <= link.load_lo;
			beat <= BURST_CNT_RST;
		end else if (link.step) begin
			beat <= 2'(beat + BURST_STEP); // R18
		end
	end

	assign link.cur_lo = burst_addr(first_lo, beat, link.interleaved);
	assign link.next_lo = burst_addr(first_lo, 2'(beat + BURST_STEP),
		link.interleaved); // R18
endmodule : sram_burst_counter

// [sram_core_if.sv]
// Links between the cycle decoder, its burst counter and its storage array.
`timescale 1ns/1ns
interface sram_core_if #(
	parameter int ADDR_W = 20,
	parameter int LANES = 4,
	parameter int BYTE_W = 8
);
	logic load;
	logic step;
	logic [1:0] load_lo;
	logic interleaved;
	logic [1:0] cur_lo;
	logic [1:0] next_lo;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [LANES-1:0] wr_lane;
	logic [LANES*BYTE_W-1:0] wr_data;
	logic [LANES-1:0] wr_par;
	logic [ADDR_W-1:0] rd_addr;
	logic [LANES*BYTE_W-1:0] rd_data;
	logic [LANES-1:0] rd_par;

	modport decoder (
		output load, step, load_lo, interleaved,
		input cur_lo, next_lo,
		output wr_en, wr_addr, wr_lane, wr_data, wr_par, rd_addr,
		input rd_data, rd_par
	);
	modport burst (
		input load, step, load_lo, interleaved,
		output cur_lo, next_lo
	);
	modport array (
		input wr_en, wr_addr, wr_lane, wr_data, wr_par, rd_addr,
		output rd_data, rd_par
	);
endinterface : sram_core_if

// [sram_cycle_decode.sv]
// Cycle decoder and data-pin control of a flow-through burst SRAM.
//
// Summary of operation
// R1: Any chip enable inactive on a load edge deselects; pins stay tri-stated.
// R2: All enables active, load, write enable high: load address, start read.
// R3: Advance edge continues the read burst at the next burst address.
// R4: Output enable high during a read gives a dummy read, pins tri-stated.
// R5: All enables active, load, write enable low, any lane: start write.
// R6: Advance edge in a write burst writes the next address; host sets lanes.
// R7: Begin-write with no lane selected is an abort; nothing is written.
// R8: Continue-write with no lane selected advances address, writes nothing.
// R9: Clock enable high makes the edge a wait state; nothing changes.
// R10: Any write cycle tri-states every data and parity pin.
// R11: Output enable acts on the pin drivers without any clocking.
// R12: Output enable is masked during writes.
// R13: In a read, pins drive only while output enable is low.
// R14: After reset the device is deselected with pins tri-stated.
// R15: Each low lane select writes its data byte and its parity bit.
// R16: Any lane select combination is legal; exactly low lanes are written.
// R17: Write data is taken on the edge after the address edge.
// R18: Burst order steps two low address bits, linear or interleaved.
// R19: Sleep request tri-states pins, ignores inputs; two cycles in and out.
// R20: Stall cycles hold counter, access type and pending write.
`timescale 1ns/1ns
module sram_cycle_decode
	import sram_cycle_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int LANES = 4,
	parameter int BYTE_W = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second_hi,
	input wire logic chip_sel_third_n,
	input wire logic sleep_request,
	input wire logic advance_or_load,
	input wire logic write_en_n,
	input wire logic [LANES-1:0] byte_write_sel_n,
	input wire logic clock_enable_n,
	input wire logic out_en_n,
	input wire logic burst_order,
	input wire logic [LANES*BYTE_W-1:0] data_in,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES*BYTE_W-1:0] data_out,
	output logic data_oe_n,
	output logic [LANES-1:0] parity_pins_out,
	output logic parity_oe_n
);
	localparam int DATA_W = LANES * BYTE_W;

	sram_core_if #(.ADDR_W(ADDR_W), .LANES(LANES), .BYTE_W(BYTE_W)) core ();

	sram_burst_counter u_burst (
		.clk_sys(clk_sys),
		.srst(srst),
		.link(core.burst)
	);

	sram_array #(.ADDR_W(ADDR_W), .LANES(LANES), .BYTE_W(BYTE_W)) u_array (
		.clk_sys(clk_sys),
		.link(core.array)
	);

	// --------------------------------------------------------------
	// Cycle decode
	// --------------------------------------------------------------
	power_state_t power_state;
	logic [1:0] sleep_cnt;
	logic awake;
	logic edge_live;
	logic loading;
	logic selected;
	logic any_lane;
	logic burst_active;
	logic burst_is_write;
	logic read_active;
	logic [ADDR_W-3:0] addr_hi;
	logic pend_write;
	logic [ADDR_W-1:0] pend_addr;
	logic [LANES-1:0] pend_lane;
	logic begin_read;
	logic begin_write;
	logic cont_read;
	logic cont_write;
	logic deselect;
	logic [ADDR_W-1:0] next_access_addr;

	assign awake = (power_state == PWR_AWAKE) && !sleep_request; // R19
	assign edge_live = awake && !clock_enable_n; // R9
	assign loading = !advance_or_load;
	assign selected = !chip_sel_first_n && chip_sel_second_hi &&
		!chip_sel_third_n;
	assign any_lane = !(&byte_write_sel_n); // R16

	assign deselect = edge_live && loading && !selected; // R1
	assign begin_read = edge_live && loading && selected && write_en_n; // R2
	assign begin_write = edge_live && loading && selected &&
		!write_en_n; // R5
	// Advance with no live burst is a continued deselect.
	assign cont_read = edge_live && !loading && burst_active &&
		!burst_is_write; // R3
	assign cont_write = edge_live && !loading && burst_active &&
		burst_is_write; // R6

	assign next_access_addr = loading ? addr : {addr_hi, core.next_lo};

	// Burst counter loads on a begin edge and steps on a continue edge only.
	assign core.load = begin_read || begin_write;
	assign core.load_lo = addr[1:0];
	assign core.step = cont_read || cont_write; // R20
	assign core.interleaved = burst_order; // R18

	// --------------------------------------------------------------
	// Burst state
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			burst_active <= BURST_ACTIVE_RST; // R14
			burst_is_write <= 1'b0;
			addr_hi <= '0;
		end else if (!awake) begin
			burst_active <= BURST_ACTIVE_RST; // R19
		end else if (deselect) begin
			burst_active <= BURST_ACTIVE_RST; // R1
		end else if (begin_read || begin_write) begin
			burst_active <= 1'b1;
			burst_is_write <= begin_write;
			addr_hi <= addr[ADDR_W-1:2];
		end
	end

	// --------------------------------------------------------------
	// Pending write: address and lanes now, data on the next live edge
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pend_write <= PEND_WRITE_RST;
			pend_lane <= '0;
			pend_addr <= '0;
		end else if (!awake) begin
			// An access caught by sleep entry is dropped.
			pend_write <= PEND_WRITE_RST; // R19
		end else if (edge_live) begin
			pend_write <= (begin_write || cont_write) && any_lane; // R7 R8
			pend_lane <= ~byte_write_sel_n; // R16
			pend_addr <= next_access_addr; // R6
		end
	end

	assign core.wr_en = edge_live && pend_write; // R17
	assign core.wr_addr = pend_addr;
	assign core.wr_lane = pend_lane; // R15
	assign core.wr_data = data_in; // R17
	assign core.wr_par = parity_in;
	assign core.rd_addr = next_access_addr;

	// --------------------------------------------------------------
	// Read data, with bypass of a write landing on the same edge
	// --------------------------------------------------------------
	logic [DATA_W-1:0] fwd_data;
	logic [LANES-1:0] fwd_par;

	always_comb begin
		fwd_data = core.rd_data;
		fwd_par = core.rd_par;
		if (core.wr_en && pend_addr == next_access_addr) begin
			for (int i = 0; i < LANES; i++) begin
				if (pend_lane[i]) begin
					fwd_data[i*BYTE_W +: BYTE_W] = data_in[i*BYTE_W +: BYTE_W];
					fwd_par[i] = parity_in[i];
				end
			end
		end
	end

	// A stall leaves the last word and read state in place, which extends
	// the previous cycle on the pins as well.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			read_active <= READ_ACTIVE_RST; // R14
			data_out <= '0;
			parity_pins_out <= '0;
		end else if (!awake) begin
			read_active <= READ_ACTIVE_RST; // R19
		end else if (edge_live) begin
			read_active <= begin_read || cont_read; // R1 R10 R12
			if (begin_read || cont_read) begin
				data_out <= fwd_data; // R2 R3 R4
				parity_pins_out <= fwd_par;
			end
		end
	end

	// --------------------------------------------------------------
	// Pin drivers
	// --------------------------------------------------------------
	// Output enable is kept out of any flip-flop so it reaches the pins
	// at once; the read flag is already clear in write cycles.
	always_comb begin
		data_oe_n = !(read_active && !out_en_n && !sleep_request); // R11 R13
		parity_oe_n = !(read_active && !out_en_n && !sleep_request); // R12
	end

	// --------------------------------------------------------------
	// Sleep entry and exit
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			power_state <= PWR_AWAKE;
			sleep_cnt <= SLEEP_CNT_RST;
		end else begin
			case (power_state)
			PWR_AWAKE: begin
				sleep_cnt <= SLEEP_CNT_RST;
				if (sleep_request) begin
					power_state <= PWR_ENTERING;
					sleep_cnt <= 2'(SLEEP_CNT_RST + BURST_STEP);
				end
			end
			PWR_ENTERING: begin
				if (!sleep_request) begin
					power_state <= PWR_WAKING;
					sleep_cnt <= 2'(SLEEP_CNT_RST + BURST_STEP);
				end else if (sleep_cnt >= 2'(SLEEP_CYCLES - BURST_STEP)) begin
					power_state <= PWR_ASLEEP; // R19
				end else begin
					sleep_cnt <= 2'(sleep_cnt + BURST_STEP);
				end
			end
			PWR_ASLEEP: begin
				if (!sleep_request) begin
					power_state <= PWR_WAKING;
					sleep_cnt <= 2'(SLEEP_CNT_RST + BURST_STEP);
				end
			end
			PWR_WAKING: begin
				if (sleep_request) begin
					power_state <= PWR_ENTERING;
					sleep_cnt <= 2'(SLEEP_CNT_RST + BURST_STEP);
				end else if (sleep_cnt >= 2'(SLEEP_CYCLES - BURST_STEP)) begin
					power_state <= PWR_AWAKE; // R19
				end else begin
					sleep_cnt <= 2'(sleep_cnt + BURST_STEP);
				end
			end
			default: begin
				power_state <= PWR_AWAKE;
			end
			endcase
		end
	end
endmodule : sram_cycle_decode

// [sram_cycle_decode_assertions.sv]
// Pin-control assertions bound to the SRAM cycle decoder.
`timescale 1ns/1ns
module sram_cycle_decode_assertions #(
	parameter int LANES = 4,
	parameter int BYTE_W = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second_hi,
	input wire logic chip_sel_third_n,
	input wire logic sleep_request,
	input wire logic advance_or_load,
	input wire logic write_en_n,
	input wire logic clock_enable_n,
	input wire logic out_en_n,
	input wire logic [LANES*BYTE_W-1:0] data_out,
	input wire logic data_oe_n,
	input wire logic parity_oe_n
);
	logic [2:0] quiet;
	logic live;
	logic sel;

	assign live = !clock_enable_n && !sleep_request;
	assign sel = !chip_sel_first_n && chip_sel_second_hi && !chip_sel_third_n;

	// Reads are judged only well after sleep, as wake-up edges are refused.
	always_ff @(posedge clk_sys)
		quiet <= srst ? 3'h7 : sleep_request ? 3'h0 : quiet + 3'(quiet != 3'h7);

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	reset_idle_a: assert property ($fell(srst) |->
		data_oe_n && data_out == '0) else $error("pins driven after reset");
	deselect_off_a: assert property (live && !advance_or_load && !sel
		|=> data_oe_n) else $error("pins driven after deselect");
	cont_deselect_a: assert property (live && advance_or_load
		&& data_oe_n && !out_en_n |=> data_oe_n)
		else $error("pins driven in continued deselect");
	read_drive_a: assert property (live && quiet == 3'h7 && sel
		&& !advance_or_load && write_en_n
		|=> data_oe_n == (out_en_n || sleep_request))
		else $error("read drive does not follow output enable");
	write_mask_a: assert property (live && !advance_or_load && sel
		&& !write_en_n |=> data_oe_n) else $error("pins driven in write");
	oe_gate_a: assert property (out_en_n |-> data_oe_n)
		else $error("pins driven with output enable high");
	sleep_off_a: assert property (sleep_request
		|-> data_oe_n && parity_oe_n) else $error("pins driven in sleep");
	lanes_oe_same_a: assert property (parity_oe_n == data_oe_n)
		else $error("parity and data enables differ");
	stall_hold_a: assert property (clock_enable_n && !sleep_request
		|=> $stable(data_out)) else $error("read data moved on a stall");
endmodule : sram_cycle_decode_assertions

bind sram_cycle_decode sram_cycle_decode_assertions #(.LANES(LANES),
	.BYTE_W(BYTE_W)) i_sram_cycle_decode_assertions (.clk_sys, .srst,
	.chip_sel_first_n, .chip_sel_second_hi, .chip_sel_third_n,
	.sleep_request, .advance_or_load, .write_en_n, .clock_enable_n,
	.out_en_n, .data_out, .data_oe_n, .parity_oe_n);

// [sram_cycle_pkg.sv]
// Shared constants, types and helpers of the flow-through SRAM cycle decoder.
package sram_cycle_pkg;

	// --------------------------------------------------------------
	// Burst and sleep timing
	// --------------------------------------------------------------
	localparam int BURST_LEN = 4;
	localparam logic [1:0] BURST_CNT_RST = 2'h0;
	localparam logic [1:0] BURST_STEP = 2'h1;
	localparam logic [1:0] SLEEP_CYCLES = 2'h2;
	localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic READ_ACTIVE_RST = 1'b0;
	localparam logic BURST_ACTIVE_RST = 1'b0;
	localparam logic PEND_WRITE_RST = 1'b0;

	typedef enum logic [1:0] {
		PWR_AWAKE = 2'b00,
		PWR_ENTERING = 2'b01,
		PWR_ASLEEP = 2'b11,
		PWR_WAKING = 2'b10
	} power_state_t;

	// Low two address bits of beat number beat, starting from first.
	function automatic logic [1:0] burst_addr(
		input logic [1:0] first,
		input logic [1:0] beat,
		input logic interleaved
	);
		burst_addr = interleaved ? (first ^ beat) : 2'(first + beat);
	endfunction : burst_addr

endpackage : sram_cycle_pkg
